// *** common/stc_bridge_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Control and feedback of one full bridge between translator and chopper.
interface stc_bridge_if;
	logic               en;
	logic               pos;
	logic               rect_dis;
	logic               trip;
	logic               below_lvl;
	logic               off_done;
	logic               zero_i;
	stc_pkg::stc_decay_t decay;
	logic [3:0]         gate;

	modport ctl (output en, pos, rect_dis, trip, below_lvl, off_done,
	             output zero_i, decay, input gate);
	modport br  (input en, pos, rect_dis, trip, below_lvl, off_done,
	             input zero_i, decay, output gate);
endinterface
`default_nettype wire

// *** common/stc_pkg.sv ***
// Function
// - Direction input decides whether the microstep index counts up or down.
// - Decay-level setting applies only to a bridge whose current falls.
// - Level above 0.6 VDD selects slow, below 0.21 VDD fast, between mixed.
// - Mixed decay: fast from trip until timing node reaches decay level.
// - After the fast part of mixed decay, slow decay for remaining off-time.
// - Translator clear held low keeps home state and turns all outputs off.
// - While translator clear is low, origin flag is low and steps ignored.
// - Origin flag is low at the home state and high anywhere else.
// - Power-up puts the translator at home, driving the origin flag low.
// - During decay, matching transistors conduct instead of body diodes.
// - Rectify-disable low rectifies, stopping at zero winding current.
// - Rectify-disable high means no synchronous rectification during decay.
// - Output gate low enables all output transistors; high disables them.
// - Step, direction and resolution are accepted whatever the output gate.
// - Doze request low disables outputs, regulator and charge pump.
// - A rising edge on doze request returns the translator home.
// - Thermal, pump-rail or low-gate-rail fault keeps outputs off.
// - Supply lockout disables drivers and resets the translator home.
// - Overcurrent longer than blanking time disables all outputs for 1.6 ms.
// - Four full steps per electrical cycle; home position at 45 degrees.
// - Resolution selects: 00 full, 01 half, 10 quarter, 11 sixteenth step.
// - Each step rise moves one increment; resolution is read at that edge.
// - New current level higher or equal to previous forces slow decay.
package stc_pkg;

	// Clock rate and the timing figures derived from it.
	localparam int unsigned CLK_MHZ    = 40;
	localparam int unsigned BLANK_NS   = 1500;
	localparam int unsigned BLANK_CYC  = (BLANK_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned LATCH_US   = 1600;
	localparam int unsigned LATCH_CYC  = LATCH_US * CLK_MHZ;
	localparam int unsigned WAKE_US    = 1000;
	localparam int unsigned LATCH_W    = 17;
	localparam int unsigned BLANK_W    = 7;

	// Translator widths and positions.
	localparam int unsigned IDX_W      = 6;
	localparam int unsigned MAG_W      = 5;
	localparam int unsigned PCT_W      = 10;
	localparam logic [5:0]  HOME_IDX   = 6'h08;
	localparam logic [5:0]  STEP_FULL  = 6'h10;
	localparam logic [5:0]  STEP_HALF  = 6'h08;
	localparam logic [5:0]  STEP_QTR   = 6'h04;
	localparam logic [5:0]  STEP_SIXT  = 6'h01;

	// Gate vector bit positions: high and low side of legs A and B.
	localparam int unsigned G_HI_A     = 3;
	localparam int unsigned G_LO_A     = 2;
	localparam int unsigned G_HI_B     = 1;
	localparam int unsigned G_LO_B     = 0;
	localparam logic [3:0]  GATE_OFF   = 4'h0;

	typedef enum logic [2:0] {
		DEC_SLOW  = 3'b001,
		DEC_FAST  = 3'b010,
		DEC_MIXED = 3'b100
	} stc_decay_t;

	typedef enum logic [3:0] {
		BR_IDLE  = 4'b0001,
		BR_DRIVE = 4'b0010,
		BR_FAST  = 4'b0100,
		BR_SLOW  = 4'b1000
	} stc_br_state_t;

	// Increment for the two resolution-select bits.
	function automatic logic [5:0] step_size(input logic [1:0] sel);
		case (sel)
			2'h0:    step_size = STEP_FULL;
			2'h1:    step_size = STEP_HALF;
			2'h2:    step_size = STEP_QTR;
			default: step_size = STEP_SIXT;
		endcase
	endfunction

	// Sine-table position of a phase: cosine for phase 1, sine for phase 2.
	function automatic logic [4:0] mag_of(input logic [5:0] idx,
	                                      input logic       ph2);
		logic [4:0] r;
		r = {1'b0, idx[3:0]};
		if (idx[4] ^ ph2)
			mag_of = r;
		else
			mag_of = 5'h10 - r;
	endfunction

	// Current sign: phase 1 negative in quadrants 1-2, phase 2 in 2-3.
	function automatic logic neg_of(input logic [5:0] idx,
	                                input logic       ph2);
		neg_of = ph2 ? idx[5] : (idx[5] ^ idx[4]);
	endfunction

	// Percent of full trip current in tenths for each table position.
	function automatic logic [9:0] pct_of(input logic [4:0] m);
		case (m)
			5'h00: pct_of = 10'h000;
			5'h01: pct_of = 10'h062;
			5'h02: pct_of = 10'h0c3;
			5'h03: pct_of = 10'h122;
			5'h04: pct_of = 10'h17f;
			5'h05: pct_of = 10'h1d7;
			5'h06: pct_of = 10'h22c;
			5'h07: pct_of = 10'h27a;
			5'h08: pct_of = 10'h2c3;
			5'h09: pct_of = 10'h305;
			5'h0a: pct_of = 10'h33f;
			5'h0b: pct_of = 10'h372;
			5'h0c: pct_of = 10'h39c;
			5'h0d: pct_of = 10'h3bd;
			5'h0e: pct_of = 10'h3d5;
			5'h0f: pct_of = 10'h3e3;
			default: pct_of = 10'h3e8;
		endcase
	endfunction

	// Decay requested by the two level comparators on the decay input.
	function automatic stc_decay_t level_decay(input logic above_hi,
	                                           input logic below_lo);
		if (above_hi)
			level_decay = DEC_SLOW;
		else if (below_lo)
			level_decay = DEC_FAST;
		else
			level_decay = DEC_MIXED;
	endfunction

endpackage

// *** dv/stc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Controller that drives the step, direction and resolution pins.
module stc_host (
	input  wire logic       clk,
	output var  logic       step,
	output var  logic       dir,
	output var  logic [1:0] sel
);
	initial begin
		step = 1'b0;
		dir = 1'b1;
		sel = 2'h0;
	end
	// One step pulse, entered 2 ns after an edge; keeps step low a cycle.
	task automatic pulse(input logic d, input logic [1:0] s);
		dir = d;
		sel = s;
		step = 1'b1;
		@(posedge clk);
		#2 step = 1'b0;
		@(posedge clk);
		#2;
	endtask
	// Pause after wake so the gate supply can settle before stepping.
	task automatic wake_wait(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, rstn = 1'b0, clear_n = 1'b1, gate_n = 1'b0;
	logic doze_n = 1'b1, rect_dis = 1'b0, above = 1'b0, below = 1'b0;
	logic therm = 1'b0, pump = 1'b0, lowg = 1'b0, lock = 1'b0, oc = 1'b0;
	logic step, dir, origin_n, n1, n2, on, reg_on, cp_on, ocl;
	logic [1:0] sel, trip = 2'h0, nbl = 2'h0, offd = 2'h0, zero = 2'h0;
	logic [5:0] sidx;
	logic [9:0] l1, l2;
	logic [2:0] d1, d2;
	logic [3:0] g1, g2;
	int error_cnt = 0, tests_run = 0, idx = 8, cyc = 0;
	// Expected positions wait here until the design shows them.
	int exp_q[$];
	int pct[17] = '{0, 98, 195, 290, 383, 471, 556, 634, 707, 773, 831,
		882, 924, 957, 981, 995, 1000};
	// A short latch-off keeps the overcurrent test brief.
	stc_top #(.LATCH_CYCLES(20)) u_dut (.CORE_CLK(clk), .RSTN(rstn),
		.STEP(step), .DIR(dir), .RESOLUTION_SEL0(sel[0]),
		.RESOLUTION_SEL1(sel[1]), .TRANSLATOR_CLEAR_N(clear_n),
		.OUTPUT_GATE_N(gate_n), .DOZE_REQUEST_N(doze_n),
		.RECTIFY_DISABLE(rect_dis), .DECAY_LEVEL_ABOVE_HI(above),
		.DECAY_LEVEL_BELOW_LO(below), .THERMAL_FAULT(therm),
		.GATE_PUMP_RAIL_LOW(pump), .LOW_GATE_RAIL_LOW(lowg),
		.SUPPLY_LOCKOUT(lock), .OVERCURRENT_TRIP(oc), .CURRENT_TRIP(trip),
		.NODE_BELOW_LEVEL(nbl), .OFFTIME_DONE(offd), .ZERO_CURRENT(zero),
		.ORIGIN_FLAG_N(origin_n), .STEP_INDEX(sidx), .PH1_LEVEL(l1),
		.PH1_NEG(n1), .PH2_LEVEL(l2), .PH2_NEG(n2), .PH1_DECAY(d1),
		.PH2_DECAY(d2), .PH1_GATE(g1), .PH2_GATE(g2), .OUTPUTS_ON(on),
		.REGULATOR_ON(reg_on), .CHARGE_PUMP_ON(cp_on),
		.OVERCURRENT_LATCHED(ocl));
	stc_host u_host (.clk(clk), .step(step), .dir(dir), .sel(sel));
	// Free-running 40 MHz clock.
	always #12.5 clk = ~clk;
	// Cuts a hang short; the wake pause alone takes 40000 cycles.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			complete_run();
		end
	end
	// Table position: cosine for phase 1, sine for phase 2.
	function automatic int mg(int i, int p);
		return ((((i / 16) % 2) ^ p) != 0) ? i % 16 : 16 - i % 16;
	endfunction
	function automatic int ng(int i, int p);
		return p ? (i >= 32) : (i / 16 == 1 || i / 16 == 2);
	endfunction
	task automatic chk(string n, logic [15:0] seen, int exp);
		tests_run++;
		if (seen !== 16'(exp)) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %0d seen %0d", n, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic done(string n);
		$display("test %s done", n);
	endtask
	// Steps the model and the design together, then compares every result.
	task automatic do_step(logic d, logic [1:0] s);
		int st, m1, m2, lv;
		st = (s == 0) ? 16 : (s == 1) ? 8 : (s == 2) ? 4 : 1;
		m1 = mg(idx, 0);
		m2 = mg(idx, 1);
		idx = d ? (idx + st) % 64 : (idx + 64 - st) % 64;
		exp_q.push_back(idx);
		lv = above ? 1 : below ? 2 : 4;
		u_host.pulse(d, s);
		chk("index", sidx, exp_q.pop_front());
		chk("origin", origin_n, idx != 8);
		chk("ph1 level", l1, pct[mg(idx, 0)]);
		chk("ph2 level", l2, pct[mg(idx, 1)]);
		chk("ph1 sign", n1, ng(idx, 0));
		chk("ph2 sign", n2, ng(idx, 1));
		chk("ph1 decay", d1, mg(idx, 0) < m1 ? lv : 1);
		chk("ph2 decay", d2, mg(idx, 1) < m2 ? lv : 1);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h1e23457f));
		repeat (12) @(posedge clk);
		#2 rstn = 1'b1;
		tick(4);
		chk("home index", sidx, 8);
		chk("home flag", origin_n, 0);
		chk("home decay", d1, 4);
		chk("outputs on", on, 1);
		// Chopper at home: both phases positive and driving.
		chk("drive gate", g1, 9);
		trip = 2'h1;
		tick(2);
		chk("fast gate", g1, 6);
		rect_dis = 1'b1;
		tick(2);
		chk("no rectify", g1, 0);
		// Timing node reaching the level turns mixed decay slow.
		rect_dis = 1'b0;
		nbl = 2'h1;
		tick(2);
		chk("slow gate", g1, 5);
		zero = 2'h1;
		tick(2);
		chk("zero stop", g1, 1);
		trip = 2'h0;
		{nbl, zero} = 4'h0;
		offd = 2'h3;
		tick(2);
		offd = 2'h0;
		gate_n = 1'b1;
		tick(2);
		chk("gate off", on, 0);
		chk("gate vec", g2, 0);
		done("chopper");
		// Random stepping with the output gate and chopper inputs moving.
		for (int k = 0; k < 60; k++) begin
			{above, below, gate_n, rect_dis} = 4'($urandom);
			{trip, nbl, offd, zero} = 8'($urandom);
			do_step(1'($urandom), 2'($urandom));
		end
		gate_n = 1'b0;
		{trip, nbl, offd, zero} = 8'h0;
		done("stepping");
		do_step(1'b1, 2'h3);
		clear_n = 1'b0;
		tick(2);
		u_host.pulse(1'b1, 2'h0);
		chk("clear index", sidx, 8);
		chk("clear flag", origin_n, 0);
		chk("clear out", on, 0);
		clear_n = 1'b1;
		idx = 8;
		tick(2);
		done("clear");
		do_step(1'b0, 2'h1);
		doze_n = 1'b0;
		tick(2);
		chk("doze out", on, 0);
		chk("doze reg", reg_on, 0);
		chk("doze pump", cp_on, 0);
		u_host.pulse(1'b1, 2'h0);
		chk("doze index", sidx, idx);
		doze_n = 1'b1;
		tick(2);
		idx = 8;
		chk("wake index", sidx, 8);
		chk("wake pump", cp_on, 1);
		u_host.wake_wait(40000);
		do_step(1'b0, 2'h2);
		done("doze");
		// Each fault source in turn; the supply lockout also homes.
		for (int k = 0; k < 4; k++) begin
			{lock, lowg, pump, therm} = 4'(1 << k);
			tick(2);
			chk("fault out", on, 0);
			if (k == 3) begin
				idx = 8;
				chk("lockout home", sidx, 8);
			end
			{lock, lowg, pump, therm} = 4'h0;
			tick(2);
			chk("fault clear", on, 1);
		end
		done("faults");
		oc = 1'b1;
		tick(60);
		chk("blank", ocl, 0);
		tick(1);
		chk("latched", ocl, 1);
		oc = 1'b0;
		tick(1);
		chk("latch out", on, 0);
		tick(25);
		chk("unlatched", ocl, 0);
		chk("latch back", on, 1);
		done("overcurrent");
		complete_run();
	end
endmodule
`default_nettype wire

// *** hw/stc_bridge.sv ***
`timescale 1ns/1ps
`default_nettype none
// Fixed off-time chopper of one full bridge with decay and rectification.
module stc_bridge (
	input  wire logic  clk,
	input  wire logic  rst_n,
	stc_bridge_if.br   b
);
	stc_pkg::stc_br_state_t state_q;
	logic                   rect;

	// Chopping sequence: drive until trip, decay until the off-time ends.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			state_q <= stc_pkg::BR_IDLE;
		else if (!b.en)
			state_q <= stc_pkg::BR_IDLE;
		else begin
			unique case (state_q)
				stc_pkg::BR_IDLE:
					state_q <= stc_pkg::BR_DRIVE;
				stc_pkg::BR_DRIVE:
					if (b.trip)
						state_q <= (b.decay == stc_pkg::DEC_SLOW) ?
						           stc_pkg::BR_SLOW : stc_pkg::BR_FAST;
				stc_pkg::BR_FAST:
					if (b.off_done)
						state_q <= stc_pkg::BR_DRIVE;
					else if (b.decay == stc_pkg::DEC_MIXED && b.below_lvl)
						state_q <= stc_pkg::BR_SLOW;
				stc_pkg::BR_SLOW:
					if (b.off_done)
						state_q <= stc_pkg::BR_DRIVE;
			endcase
		end
	end

	// Rectify only when allowed and while the winding still carries current.
	assign rect = !b.rect_dis && !b.zero_i;

	// Gate pattern per state; pos picks the leg that sources the current.
	always_comb begin
		b.gate = stc_pkg::GATE_OFF;
		unique case (state_q)
			stc_pkg::BR_IDLE:
				b.gate = stc_pkg::GATE_OFF;
			stc_pkg::BR_DRIVE: begin
				b.gate[stc_pkg::G_HI_A] = b.pos;
				b.gate[stc_pkg::G_LO_B] = b.pos;
				b.gate[stc_pkg::G_HI_B] = !b.pos;
				b.gate[stc_pkg::G_LO_A] = !b.pos;
			end
			stc_pkg::BR_FAST: begin
				// Reverse diagonal conducts instead of the diodes.
				b.gate[stc_pkg::G_HI_B] = rect && b.pos;
				b.gate[stc_pkg::G_LO_A] = rect && b.pos;
				b.gate[stc_pkg::G_HI_A] = rect && !b.pos;
				b.gate[stc_pkg::G_LO_B] = rect && !b.pos;
			end
			stc_pkg::BR_SLOW: begin
				// Sink stays on; the other low side shorts its diode.
				b.gate[stc_pkg::G_LO_B] = b.pos || rect;
				b.gate[stc_pkg::G_LO_A] = !b.pos || rect;
			end
		endcase
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_mixed_to_slow: assert property (
		b.en && state_q == stc_pkg::BR_FAST && !b.off_done &&
		b.decay == stc_pkg::DEC_MIXED && b.below_lvl
		|=> state_q == stc_pkg::BR_SLOW)
		else $error("mixed decay did not turn slow");

	a_no_rectify: assert property (
		b.rect_dis && state_q == stc_pkg::BR_FAST |-> b.gate == 4'h0)
		else $error("rectification while disabled");

	a_zero_stop: assert property (
		b.zero_i && state_q == stc_pkg::BR_SLOW
		|-> !(b.gate[stc_pkg::G_LO_A] && b.gate[stc_pkg::G_LO_B]))
		else $error("rectifying at zero current");
endmodule
`default_nettype wire

// *** hw/stc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Translator, decay selection and protection of a two-phase stepper driver.
module stc_top #(
	parameter int unsigned LATCH_CYCLES = stc_pkg::LATCH_CYC
) (
	input  wire logic       CORE_CLK,
	input  wire logic       RSTN,
	input  wire logic       STEP,
	input  wire logic       DIR,
	input  wire logic       RESOLUTION_SEL0,
	input  wire logic       RESOLUTION_SEL1,
	input  wire logic       TRANSLATOR_CLEAR_N,
	input  wire logic       OUTPUT_GATE_N,
	input  wire logic       DOZE_REQUEST_N,
	input  wire logic       RECTIFY_DISABLE,
	input  wire logic       DECAY_LEVEL_ABOVE_HI,
	input  wire logic       DECAY_LEVEL_BELOW_LO,
	input  wire logic       THERMAL_FAULT,
	input  wire logic       GATE_PUMP_RAIL_LOW,
	input  wire logic       LOW_GATE_RAIL_LOW,
	input  wire logic       SUPPLY_LOCKOUT,
	input  wire logic       OVERCURRENT_TRIP,
	input  wire logic [1:0] CURRENT_TRIP,
	input  wire logic [1:0] NODE_BELOW_LEVEL,
	input  wire logic [1:0] OFFTIME_DONE,
	input  wire logic [1:0] ZERO_CURRENT,
	output var  logic       ORIGIN_FLAG_N,
	output var  logic [5:0] STEP_INDEX,
	output var  logic [9:0] PH1_LEVEL,
	output var  logic       PH1_NEG,
	output var  logic [9:0] PH2_LEVEL,
	output var  logic       PH2_NEG,
	output var  logic [2:0] PH1_DECAY,
	output var  logic [2:0] PH2_DECAY,
	output var  logic [3:0] PH1_GATE,
	output var  logic [3:0] PH2_GATE,
	output var  logic       OUTPUTS_ON,
	output var  logic       REGULATOR_ON,
	output var  logic       CHARGE_PUMP_ON,
	output var  logic       OVERCURRENT_LATCHED
);
	localparam logic [16:0] LATCH_LOAD = 17'(LATCH_CYCLES - 1);
	localparam logic [6:0]  BLANK_LIM  = 7'(stc_pkg::BLANK_CYC);

	logic                   rst_meta_q;
	logic                   rst_n;
	logic                   step_q;
	logic                   doze_q;
	logic                   step_rise;
	logic                   doze_rise;
	logic                   home_req;
	logic                   step_ok;
	logic [5:0]             idx_q;
	logic [5:0]             idx_d;
	logic [5:0]             delta;
	logic                   fault;
	logic [6:0]             oc_cnt_q;
	logic                   ocp_q;
	logic [16:0]            latch_cnt_q;
	logic                   en_d;
	stc_pkg::stc_decay_t    lvl_decay;
	stc_pkg::stc_decay_t    dec_q [2];
	logic [4:0]             mag_new [2];
	logic [4:0]             mag_old [2];

	stc_bridge_if bif [2] ();

	// Reset release through two flops; assertion stays asynchronous.
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// Previous levels of step and doze for edge detection.
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			step_q <= 1'b0;
			doze_q <= 1'b1;
		end else begin
			step_q <= STEP;
			doze_q <= DOZE_REQUEST_N;
		end
	end

	// Doze history starts at the idle level, so no false wake edge
	// follows reset; a low input at release still wakes on its rise.
	assign step_rise = STEP && !step_q;
	assign doze_rise = DOZE_REQUEST_N && !doze_q;

	// Conditions that force home, and steps that are accepted.
	assign home_req = !TRANSLATOR_CLEAR_N ||
	                  SUPPLY_LOCKOUT ||
	                  doze_rise;
	// The output gate plays no part in accepting a step.
	assign step_ok  = step_rise && TRANSLATOR_CLEAR_N &&
	                  DOZE_REQUEST_N && !SUPPLY_LOCKOUT;

	// Resolution is sampled only on the accepted edge.
	assign delta = stc_pkg::step_size({RESOLUTION_SEL1, RESOLUTION_SEL0});

	// Next index: six bits wrap modulo 64 in both directions.
	always_comb begin
		idx_d = idx_q;
		if (home_req)
			idx_d = stc_pkg::HOME_IDX;
		else if (step_ok)
			idx_d = DIR ? 6'(idx_q + delta) : 6'(idx_q - delta);
	end

	// Translator position; reset is the power-up home state.
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n)
			idx_q <= stc_pkg::HOME_IDX;
		else
			idx_q <= idx_d;
	end

	// Decay the level input asks for when a bridge's current falls.
	assign lvl_decay = stc_pkg::level_decay(DECAY_LEVEL_ABOVE_HI,
	                                        DECAY_LEVEL_BELOW_LO);

	// Per-phase decay: compare new and old table positions on each step.
	for (genvar p = 0; p < 2; p++) begin : g_phase
		assign mag_new[p] = stc_pkg::mag_of(idx_d, 1'(p));
		assign mag_old[p] = stc_pkg::mag_of(idx_q, 1'(p));

		always_ff @(posedge CORE_CLK or negedge rst_n) begin
			if (!rst_n)
				dec_q[p] <= stc_pkg::DEC_MIXED;
			else if (home_req)
				dec_q[p] <= stc_pkg::DEC_MIXED;
			else if (step_ok) begin
				if (mag_new[p] < mag_old[p])
					dec_q[p] <= lvl_decay;
				else
					dec_q[p] <= stc_pkg::DEC_SLOW;
			end
		end

		// Chopper feedback passes straight through to each bridge.
		assign bif[p].en        = en_d;
		assign bif[p].pos       = !stc_pkg::neg_of(idx_q, 1'(p));
		assign bif[p].rect_dis  = RECTIFY_DISABLE;
		assign bif[p].trip      = CURRENT_TRIP[p];
		assign bif[p].below_lvl = NODE_BELOW_LEVEL[p];
		assign bif[p].off_done  = OFFTIME_DONE[p];
		assign bif[p].zero_i    = ZERO_CURRENT[p];
		assign bif[p].decay     = dec_q[p];

		stc_bridge u_bridge (
			.clk   (CORE_CLK),
			.rst_n (rst_n),
			.b     (bif[p])
		);
	end

	// Any fault holds the outputs off for as long as it is present.
	assign fault = THERMAL_FAULT || GATE_PUMP_RAIL_LOW ||
	               LOW_GATE_RAIL_LOW;

	// Overcurrent must persist past the blanking time before it counts,
	// so switching spikes shorter than that never trip the latch.
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n)
			oc_cnt_q <= 7'h00;
		else if (!OVERCURRENT_TRIP || ocp_q)
			oc_cnt_q <= 7'h00;
		else if (oc_cnt_q != BLANK_LIM)
			oc_cnt_q <= oc_cnt_q + 7'h01;
	end

	// Latch-off timer; it runs out by itself, no software clear.
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ocp_q       <= 1'b0;
			latch_cnt_q <= 17'h00000;
		end else if (!ocp_q) begin
			if (OVERCURRENT_TRIP && oc_cnt_q == BLANK_LIM) begin
				ocp_q       <= 1'b1;
				latch_cnt_q <= LATCH_LOAD;
			end
		end else if (latch_cnt_q == 17'h00000)
			ocp_q <= 1'b0;
		else
			latch_cnt_q <= latch_cnt_q - 17'h00001;
	end

	// Everything that may keep the bridges dark.
	assign en_d = TRANSLATOR_CLEAR_N &&
	              !OUTPUT_GATE_N &&
	              DOZE_REQUEST_N &&
	              !fault && !SUPPLY_LOCKOUT && !ocp_q;

	// Gate outputs are re-masked here so a disable takes one edge only.
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			PH1_GATE   <= stc_pkg::GATE_OFF;
			PH2_GATE   <= stc_pkg::GATE_OFF;
			OUTPUTS_ON <= 1'b0;
		end else begin
			PH1_GATE   <= en_d ? bif[0].gate : stc_pkg::GATE_OFF;
			PH2_GATE   <= en_d ? bif[1].gate : stc_pkg::GATE_OFF;
			OUTPUTS_ON <= en_d;
		end
	end

	// Regulator and charge pump follow the doze request.
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			REGULATOR_ON   <= 1'b0;
			CHARGE_PUMP_ON <= 1'b0;
		end else begin
			REGULATOR_ON   <= DOZE_REQUEST_N;
			CHARGE_PUMP_ON <= DOZE_REQUEST_N;
		end
	end

	// Translator view: position, origin flag and phase currents.
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ORIGIN_FLAG_N <= 1'b0;
			STEP_INDEX    <= stc_pkg::HOME_IDX;
			PH1_LEVEL     <= stc_pkg::pct_of(5'h08);
			PH1_NEG       <= 1'b0;
			PH2_LEVEL     <= stc_pkg::pct_of(5'h08);
			PH2_NEG       <= 1'b0;
		end else begin
			ORIGIN_FLAG_N <= idx_d != stc_pkg::HOME_IDX;
			STEP_INDEX    <= idx_d;
			PH1_LEVEL     <= stc_pkg::pct_of(stc_pkg::mag_of(idx_d, 1'b0));
			PH1_NEG       <= stc_pkg::neg_of(idx_d, 1'b0);
			PH2_LEVEL     <= stc_pkg::pct_of(stc_pkg::mag_of(idx_d, 1'b1));
			PH2_NEG       <= stc_pkg::neg_of(idx_d, 1'b1);
		end
	end

	// Decay modes as seen by the analog chopper and by the outside.
	assign PH1_DECAY = dec_q[0];
	assign PH2_DECAY = dec_q[1];
	assign OVERCURRENT_LATCHED = ocp_q;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!rst_n);

	sequence s_accept;
		step_ok && !home_req;
	endsequence

	sequence s_clear_held;
		!TRANSLATOR_CLEAR_N ##1 !TRANSLATOR_CLEAR_N;
	endsequence

	a_clear_home: assert property (
		s_clear_held |-> idx_q == stc_pkg::HOME_IDX && !ORIGIN_FLAG_N &&
		PH1_GATE == 4'h0 && PH2_GATE == 4'h0)
		else $error("translator clear did not hold home");

	a_flag_match: assert property (
		ORIGIN_FLAG_N == (idx_q != stc_pkg::HOME_IDX))
		else $error("origin flag disagrees with position");

	a_step_up_fine: assert property (
		s_accept ##0 (DIR && RESOLUTION_SEL0 && RESOLUTION_SEL1)
		|=> idx_q == 6'($past(idx_q) + 6'h01))
		else $error("sixteenth step up wrong");

	a_step_dn_full: assert property (
		s_accept ##0 (!DIR && !RESOLUTION_SEL0 && !RESOLUTION_SEL1)
		|=> idx_q == 6'($past(idx_q) - 6'h10))
		else $error("full step down wrong");

	a_gate_steps: assert property (
		s_accept ##0 OUTPUT_GATE_N |=> idx_q != $past(idx_q))
		else $error("step lost while outputs gated");

	a_idle_still: assert property (
		!step_rise && !home_req |=> $stable(idx_q))
		else $error("index moved without a step edge");

	a_gate_off: assert property (
		OUTPUT_GATE_N |=> PH1_GATE == 4'h0 && PH2_GATE == 4'h0 &&
		!OUTPUTS_ON)
		else $error("outputs on while gated off");

	a_doze_off: assert property (
		!DOZE_REQUEST_N |=> !OUTPUTS_ON && !REGULATOR_ON && !CHARGE_PUMP_ON)
		else $error("doze did not shut down");

	a_wake_home: assert property (
		$rose(DOZE_REQUEST_N) |=> idx_q == stc_pkg::HOME_IDX)
		else $error("wake edge did not return home");

	a_fault_off: assert property (
		fault |=> !OUTPUTS_ON)
		else $error("outputs on during fault");

	a_lockout_home: assert property (
		SUPPLY_LOCKOUT |=> !OUTPUTS_ON && idx_q == stc_pkg::HOME_IDX)
		else $error("lockout did not disable and home");

	a_ocp_blank: assert property (
		$rose(ocp_q) |-> $past(oc_cnt_q) == BLANK_LIM &&
		$past(OVERCURRENT_TRIP))
		else $error("overcurrent latched before blanking time");

	a_ocp_hold: assert property (
		$rose(ocp_q) |-> latch_cnt_q == LATCH_LOAD ##1 !OUTPUTS_ON[*8])
		else $error("overcurrent latch-off wrong");

	a_decay_slow: assert property (
		s_accept ##0 (mag_new[0] >= mag_old[0])
		|=> dec_q[0] == stc_pkg::DEC_SLOW)
		else $error("rising current not slow decay");

	a_decay_fast: assert property (
		s_accept ##0 (mag_new[1] < mag_old[1] && DECAY_LEVEL_BELOW_LO &&
		!DECAY_LEVEL_ABOVE_HI) |=> dec_q[1] == stc_pkg::DEC_FAST)
		else $error("falling current ignored decay level");

	a_step_half: assert property (
		s_accept ##0 (DIR && RESOLUTION_SEL0 && !RESOLUTION_SEL1)
		|=> idx_q == 6'($past(idx_q) + 6'h08))
		else $error("half step up wrong");

	a_step_qtr_dn: assert property (
		s_accept ##0 (!DIR && !RESOLUTION_SEL0 && RESOLUTION_SEL1)
		|=> idx_q == 6'($past(idx_q) - 6'h04))
		else $error("quarter step down wrong");

	a_home_mixed: assert property (
		home_req |=> dec_q[0] == stc_pkg::DEC_MIXED &&
		dec_q[1] == stc_pkg::DEC_MIXED)
		else $error("home did not restore mixed decay");

	a_latch_expire: assert property (
		ocp_q && latch_cnt_q == 17'h00000 |=> !ocp_q)
		else $error("overcurrent latch did not expire");
endmodule
`default_nettype wire
